// ==== hw/crcs_pkg.sv ====
// Shared constants and carrier types for the card run command and status block
package crcs_pkg;

  // Register offsets on the register port, kept as printed
  localparam int unsigned ADDR_W         = 20;
  localparam logic [19:0] OFS_COMMAND    = 20'h00064;
  localparam logic [19:0] OFS_STATUS     = 20'h0006E;
  localparam logic [19:0] OFS_TIMEOUT_MS = 20'h480DA;

  // Command register bit positions
  localparam int unsigned CMD_FULL_RESET      = 0;
  localparam int unsigned CMD_PUSH_CONFIG     = 1;
  localparam int unsigned CMD_BEGIN_RUN       = 2;
  localparam int unsigned CMD_TRIG_DETECT_ON  = 3;
  localparam int unsigned CMD_TRIG_FORCE      = 4;
  localparam int unsigned CMD_TRIG_DETECT_OFF = 5;
  localparam int unsigned CMD_END_RUN         = 6;
  localparam int unsigned WAIT_PRETRIG_FULL   = 12;
  localparam int unsigned WAIT_FIRST_TRIG     = 13;
  localparam int unsigned WAIT_RUN_DONE       = 14;
  localparam logic [31:0] CMD_KNOWN_MASK      = 32'h0000707F;

  // Status register bit positions
  localparam int unsigned STAT_PRETRIG_FULL = 0;
  localparam int unsigned STAT_TRIG_SEEN    = 1;
  localparam int unsigned STAT_RUN_DONE     = 2;

  // Reset values
  localparam logic [31:0] TIMEOUT_RST = 32'h00000000;
  localparam logic [2:0]  STATUS_RST  = 3'h0;

  // Result codes returned for writes and waits
  localparam logic [2:0] RES_OK      = 3'h0;
  localparam logic [2:0] RES_SEQ     = 3'h1;
  localparam logic [2:0] RES_TIMEOUT = 3'h2;
  localparam logic [2:0] RES_ABORT   = 3'h3;
  localparam logic [2:0] RES_BADREG  = 3'h4;

  // Timing: one millisecond at the reference clock
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  // Events from the acquisition or replay engine
  typedef struct packed {
    logic pretrig_filled;
    logic trig_event;
    logic run_complete;
  } crcs_evt_t;

  // Control strobes and levels toward the engine
  typedef struct packed {
    logic card_reset;
    logic push_config;
    logic run_active;
    logic trig_enable;
    logic trig_fire;
  } crcs_ctl_t;

endpackage

// ==== hw/crcs_ms_timer.sv ====
// Millisecond wait timeout timer
`timescale 1ns/100ps
module crcs_ms_timer #(
  parameter int unsigned CYCLES_PER_MS = crcs_pkg::CYCLES_PER_MS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_cancel,
  input  wire logic [31:0] i_limit_ms,
  output logic             o_expired
);

  // Divider needs at least two cycles per millisecond
  if (CYCLES_PER_MS < 2)
  begin : g_bad_cycles
    $error("crcs_ms_timer: CYCLES_PER_MS must be at least 2");
  end

  logic        running;
  logic [31:0] div_cnt;
  logic [31:0] ms_left;
  logic        ms_tick;

  // Divider restarts with each wait so the first millisecond is whole
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      div_cnt <= 32'h00000000;
    else if (i_start || !running || ms_tick)
      div_cnt <= 32'h00000000;
    else
      div_cnt <= div_cnt + 32'h00000001;
  end

  assign ms_tick = running && (div_cnt == CYCLES_PER_MS - 1);

  // Zero limit never arms, so the wait blocks until its event
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      running   <= 1'b0;
      ms_left   <= 32'h00000000;
      o_expired <= 1'b0;
    end
    else
    begin
      o_expired <= 1'b0;
      if (i_cancel)
        running <= 1'b0;
      else if (i_start)
      begin
        running <= (i_limit_ms != 32'h00000000);
        ms_left <= i_limit_ms;
      end
      else if (ms_tick)
      begin
        if (ms_left == 32'h00000001)
        begin
          running   <= 1'b0;
          o_expired <= 1'b1;
        end
        ms_left <= ms_left - 32'h00000001;
      end
    end
  end

endmodule

// ==== hw/crcs_card_run.sv ====
// Card run control: command decode, status bitmap, trigger gating and wait handling
//
// Functional notes
// - One write may carry several command bits; each set bit acts as its own command.
// - Any disallowed or meaningless bit combination rejects the whole write with sequence error.
// - Bit 1h performs a full card reset.
// - Bit 2h pushes pending configuration to hardware without starting a run.
// - Bit 4h starts a run, pushing configuration first if settings changed.
// - Bit 8h enables trigger detection, with start or later.
// - Bit 10h forces a trigger event immediately; with start it acts as software trigger.
// - Bit 20h disables trigger detection until enabled again.
// - Start leaves trigger detection off unless enable is given too.
// - Bit 40h ends the run; when idle it only aborts a pending wait.
// - Waits end with success on their event, or timeout code when time runs out.
// - A pending wait returns abort when stop or reset is issued.
// - Wait 1000h, acquisition only, blocks until pretrigger area filled once.
// - Triggers are evaluated only while detection enabled and, in acquisition mode, after pretrigger filled.
// - Wait 2000h blocks until first trigger; later triggers do not serve it.
// - Wait 4000h blocks until the run completes.
// - Timeout register holds limit in milliseconds; zero means wait forever.
// - Timeout defaults to disabled and stays in force until rewritten or a full reset disables it.
// - Timeout expiry leaves the card state untouched.
// - Status register is a read-only bitmap with several bits set together.
// - Status 1h pretrigger full, 2h first trigger, 4h run done.
`timescale 1ns/100ps
module crcs_card_run #(
  parameter int unsigned CYCLES_PER_MS = crcs_pkg::CYCLES_PER_MS
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  input  wire logic [19:0]          i_addr,
  input  wire logic [31:0]          i_wdata,
  output logic                      o_ack,
  output logic [2:0]                o_code,
  output logic                      o_rd_valid,
  output logic [31:0]               o_rd_data,
  output logic                      o_wait_done,
  output logic [2:0]                o_wait_code,
  input  wire crcs_pkg::crcs_evt_t  i_evt,
  input  wire logic                 i_acq_mode,
  input  wire logic                 i_cfg_changed,
  output crcs_pkg::crcs_ctl_t       o_ctl
);

  // Timer divider cannot serve fewer than two cycles per millisecond
  if (CYCLES_PER_MS < 2)
  begin : g_bad_cycles
    $error("crcs_card_run: CYCLES_PER_MS must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic        cmd_wr;
  logic        seq_err;
  logic        accepted;
  logic [2:0]  wait_req;
  logic        c_reset;
  logic        c_push;
  logic        c_start;
  logic        c_on;
  logic        c_force;
  logic        c_off;
  logic        c_stop;
  logic        run_active;
  logic        trig_enable;
  logic [2:0]  status;
  logic        wait_pend;
  logic [2:0]  wait_mask;
  logic [31:0] timeout_ms;
  logic        tmr_expired;
  logic        wait_met;
  logic        wait_abort;
  logic        trig_fire_now;

  assign cmd_wr   = i_wr && (i_addr == crcs_pkg::OFS_COMMAND);
  assign c_reset  = i_wdata[crcs_pkg::CMD_FULL_RESET];
  assign c_push   = i_wdata[crcs_pkg::CMD_PUSH_CONFIG];
  assign c_start  = i_wdata[crcs_pkg::CMD_BEGIN_RUN];
  assign c_on     = i_wdata[crcs_pkg::CMD_TRIG_DETECT_ON];
  assign c_force  = i_wdata[crcs_pkg::CMD_TRIG_FORCE];
  assign c_off    = i_wdata[crcs_pkg::CMD_TRIG_DETECT_OFF];
  assign c_stop   = i_wdata[crcs_pkg::CMD_END_RUN];
  assign wait_req = {i_wdata[crcs_pkg::WAIT_RUN_DONE], i_wdata[crcs_pkg::WAIT_FIRST_TRIG],
                     i_wdata[crcs_pkg::WAIT_PRETRIG_FULL]};

  // Whole write refused on any conflict; no bit of it takes effect
  always_comb
  begin
    seq_err = 1'b0;
    if ((i_wdata & ~crcs_pkg::CMD_KNOWN_MASK) != 32'h00000000)
      seq_err = 1'b1;
    if (c_reset && ((i_wdata[6:1] != 6'h00) || (wait_req != 3'h0)))
      seq_err = 1'b1;
    if (c_start && (run_active || c_stop))
      seq_err = 1'b1;
    if (c_on && c_off)
      seq_err = 1'b1;
    if (c_force && !run_active && !c_start)
      seq_err = 1'b1;
    if (c_stop && (wait_req != 3'h0))
      seq_err = 1'b1;
    if (wait_req[0] && !i_acq_mode)
      seq_err = 1'b1;
    if (wait_pend && (wait_req != 3'h0))
      seq_err = 1'b1;
  end

  assign accepted = cmd_wr && !seq_err;

  ////////////////////////////////////////////////////////////////////////////
  // Write answer and register reads

  // Every write is answered one cycle later with its code
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ack  <= 1'b0;
      o_code <= crcs_pkg::RES_OK;
    end
    else
    begin
      o_ack <= i_wr;
      if (cmd_wr)
        o_code <= seq_err ? crcs_pkg::RES_SEQ : crcs_pkg::RES_OK;
      else if (i_wr && (i_addr == crcs_pkg::OFS_TIMEOUT_MS))
        o_code <= crcs_pkg::RES_OK;
      else if (i_wr)
        o_code <= crcs_pkg::RES_BADREG;
    end
  end

  // Command reads as zero, status bits above 4h read as zero
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 32'h00000000;
    end
    else
    begin
      o_rd_valid <= i_rd;
      if (i_rd && (i_addr == crcs_pkg::OFS_STATUS))
        o_rd_data <= {29'h00000000, status};
      else if (i_rd && (i_addr == crcs_pkg::OFS_TIMEOUT_MS))
        o_rd_data <= timeout_ms;
      else if (i_rd)
        o_rd_data <= 32'h00000000;
    end
  end

  // Timeout limit survives across waits; full reset returns it to off
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      timeout_ms <= crcs_pkg::TIMEOUT_RST;
    else if (accepted && c_reset)
      timeout_ms <= crcs_pkg::TIMEOUT_RST;
    else if (i_wr && (i_addr == crcs_pkg::OFS_TIMEOUT_MS))
      timeout_ms <= i_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run and trigger control

  // Run ends on stop, reset or completion from the engine
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      run_active <= 1'b0;
    else if (accepted && (c_reset || c_stop))
      run_active <= 1'b0;
    else if (accepted && c_start)
      run_active <= 1'b1;
    else if (i_evt.run_complete)
      run_active <= 1'b0;
  end

  // Detection always starts off unless enable rides with start
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      trig_enable <= 1'b0;
    else if (accepted && c_reset)
      trig_enable <= 1'b0;
    else if (accepted && c_start)
      trig_enable <= c_on;
    else if (accepted && c_on)
      trig_enable <= 1'b1;
    else if (accepted && c_off)
      trig_enable <= 1'b0;
  end

  // Generation has no pretrigger area, so it is not gated there
  assign trig_fire_now = (accepted && c_force) ||
                         (run_active && trig_enable && i_evt.trig_event &&
                          (status[crcs_pkg::STAT_PRETRIG_FULL] || !i_acq_mode));

  // Strobes toward the engine are one cycle wide
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_ctl <= '0;
    else
    begin
      o_ctl.card_reset  <= accepted && c_reset;
      o_ctl.push_config <= accepted && (c_push || (c_start && i_cfg_changed));
      o_ctl.trig_fire   <= trig_fire_now;
      o_ctl.run_active  <= run_active;
      o_ctl.trig_enable <= trig_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bitmap

  // Start clears before the sets, keeping an event of that cycle; full reset drops all
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      status <= crcs_pkg::STATUS_RST;
    else
    begin
      logic [2:0] next_status;
      next_status = status;
      if (accepted && c_start)
        next_status = 3'h0;
      if (run_active && i_acq_mode && i_evt.pretrig_filled)
        next_status[crcs_pkg::STAT_PRETRIG_FULL] = 1'b1;
      if (trig_fire_now)
        next_status[crcs_pkg::STAT_TRIG_SEEN] = 1'b1;
      if (run_active && (i_evt.run_complete || (accepted && c_stop)))
        next_status[crcs_pkg::STAT_RUN_DONE] = 1'b1;
      if (accepted && c_reset)
        next_status = 3'h0;
      status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait handling

  // All requested targets must be reached; trig_seen is sticky so later triggers add nothing
  assign wait_met   = wait_pend && ((wait_mask & ~status) == 3'h0);
  assign wait_abort = wait_pend && accepted && (c_stop || c_reset);

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wait_pend   <= 1'b0;
      wait_mask   <= 3'h0;
      o_wait_done <= 1'b0;
      o_wait_code <= crcs_pkg::RES_OK;
    end
    else
    begin
      o_wait_done <= 1'b0;
      if (wait_abort)
      begin
        wait_pend   <= 1'b0;
        o_wait_done <= 1'b1;
        o_wait_code <= crcs_pkg::RES_ABORT;
      end
      else if (wait_met)
      begin
        wait_pend   <= 1'b0;
        o_wait_done <= 1'b1;
        o_wait_code <= crcs_pkg::RES_OK;
      end
      else if (wait_pend && tmr_expired)
      begin
        wait_pend   <= 1'b0;
        o_wait_done <= 1'b1;
        o_wait_code <= crcs_pkg::RES_TIMEOUT;
      end
      else if (accepted && (wait_req != 3'h0))
      begin
        wait_pend <= 1'b1;
        wait_mask <= wait_req;
      end
    end
  end

  // Timer only reports; expiry never touches run or status state
  crcs_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_timer (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_start    (accepted && (wait_req != 3'h0)),
    .i_cancel   (wait_pend && (wait_abort || wait_met)),
    .i_limit_ms (timeout_ms),
    .o_expired  (tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_seq_reject: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cmd_wr && seq_err) |=> (o_ack && o_code == crcs_pkg::RES_SEQ && !o_ctl.card_reset && !o_ctl.push_config))
    else $error("refused write had an effect or wrong code");

  a_reset_strobe: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (accepted && c_reset) |=> (o_ctl.card_reset && !run_active && status == 3'h0 && timeout_ms == 32'h0))
    else $error("full reset did not clear state");

  a_push_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (accepted && c_push && !c_start) |=> (o_ctl.push_config && !$rose(run_active)))
    else $error("push config missing or started run");

  a_start_arms: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (accepted && c_start) |=> (run_active && trig_enable == $past(c_on) && status[0] == 1'b0))
    else $error("start left wrong trigger or status state");

  a_force_fires: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (accepted && c_force) |=> (o_ctl.trig_fire && status[crcs_pkg::STAT_TRIG_SEEN]))
    else $error("forced trigger not produced");

  a_trig_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_evt.trig_event && i_acq_mode && !status[0] && !(accepted && c_force)) |=> !o_ctl.trig_fire)
    else $error("trigger passed before pretrigger full");

  a_stop_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (accepted && c_stop && !run_active) |=> $stable(status))
    else $error("stop while idle changed status");

  a_wait_abort: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wait_abort |=> (o_wait_done && o_wait_code == crcs_pkg::RES_ABORT) ##1 !o_wait_done)
    else $error("pending wait not aborted");

  a_wait_ok: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wait_met && !wait_abort) |=> (o_wait_done && o_wait_code == crcs_pkg::RES_OK && !wait_pend))
    else $error("reached wait target not reported");

  a_timeout_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wait_pend && tmr_expired && !wait_met && !wait_abort && !cmd_wr && !i_evt.run_complete)
      |=> ($stable(run_active) && o_wait_code == crcs_pkg::RES_TIMEOUT))
    else $error("timeout changed run state");

  c_run_done: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wait_done && o_wait_code == crcs_pkg::RES_OK && status[crcs_pkg::STAT_RUN_DONE]);
  c_timeout: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wait_done && o_wait_code == crcs_pkg::RES_TIMEOUT);
  c_abort: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wait_done && o_wait_code == crcs_pkg::RES_ABORT);
  c_real_trig: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_ctl.trig_fire && status[0]);

endmodule

// ==== verification/crcs_card_run_tb.sv ====
// Self-checking bench for the card run command and status block
`timescale 1ns/100ps
module tb;
  localparam int MS = 10;
  logic                i_ref_clk     = 1'b0;
  logic                i_rst         = 1'b1;
  logic                i_wr          = 1'b0;
  logic                i_rd          = 1'b0;
  logic [19:0]         i_addr        = 20'h00000;
  logic [31:0]         i_wdata       = 32'h00000000;
  logic                i_acq_mode    = 1'b1;
  logic                i_cfg_changed = 1'b0;
  crcs_pkg::crcs_evt_t i_evt         = '0;
  logic                o_ack;
  logic                o_rd_valid;
  logic                o_wait_done;
  logic [2:0]          o_code;
  logic [2:0]          o_wait_code;
  logic [31:0]         o_rd_data;
  crcs_pkg::crcs_ctl_t o_ctl;
  // Behavioural model state and scoreboard counters
  logic [2:0]          st = 3'h0;
  logic [2:0]          wcode;
  bit                  run;
  bit                  ten;
  int                  n_errors, n_checks, np, nf, nr, nwd, ex_p, ex_f, ex_r, ex_w, k, t;
  int                  seed = 90509;
  logic [31:0]         bad[6] = '{32'h80, 32'h5, 32'h10, 32'h28, 32'h4040, 32'h1000};

  crcs_card_run #(.CYCLES_PER_MS(MS)) i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack), .o_code(o_code), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_wait_done(o_wait_done), .o_wait_code(o_wait_code), .i_evt(i_evt),
    .i_acq_mode(i_acq_mode), .i_cfg_changed(i_cfg_changed), .o_ctl(o_ctl));

  // Clock at 4 ns
  initial
  begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // Pulse counters; sampling on the edge sees settled values
  always @(posedge i_ref_clk)
  begin
    np += (o_ctl.push_config === 1'b1);
    nf += (o_ctl.trig_fire === 1'b1);
    nr += (o_ctl.card_reset === 1'b1);
    if (o_wait_done === 1'b1)
    begin
      nwd++;
      wcode = o_wait_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // One register cycle; caller stands just after an edge
  // An idle edge first, so a strobe never drops and rises in one time step
  task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    #1;
    i_wr = w;
    i_rd = !w;
    i_addr = a;
    i_wdata = d;
    @(posedge i_ref_clk);
    #1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    k = 0;
    while ((w ? o_ack : o_rd_valid) !== 1'b1 && k < 4)
    begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    chk("answer", k < 4, 1'b1);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("rdata", o_rd_data, e);
  endtask

  // Legality of a command word in the model's present state
  function automatic bit legal(input logic [31:0] c);
    return !((c & ~crcs_pkg::CMD_KNOWN_MASK) != 0 || (c[0] && c != 32'h1) || (c[2] && (run || c[6]))
      || (c[3] && c[5]) || (c[4] && !run && !c[2]) || (c[6] && c[14:12] != 0) || (c[12] && !i_acq_mode));
  endfunction

  // Command write; start acts before enable so both may share a word
  task automatic cmd(input logic [31:0] c);
    logic [2:0] e;
    e = legal(c) ? crcs_pkg::RES_OK : crcs_pkg::RES_SEQ;
    bus(1'b1, crcs_pkg::OFS_COMMAND, c);
    chk("code", o_code, e);
    if (e == crcs_pkg::RES_OK)
    begin
      if (c[0]) {run, ten, st, ex_r} = {5'h0, ex_r + 1};
      if (c[2]) {run, ten, st} = 5'b10000;
      ex_p += int'((c[2] && i_cfg_changed) || c[1]);
      if (c[3]) ten = 1'b1;
      if (c[5]) ten = 1'b0;
      ex_f += int'(c[4]);
      if (c[4]) st[1] = 1'b1;
      if (c[6] && run) {run, st[2]} = 2'b01;
    end
  endtask

  // Engine event pulse of one cycle, mirrored in the model
  task automatic ev(input logic [2:0] e);
    i_evt = e;
    if (e[2] && run && i_acq_mode) st[0] = 1'b1;
    if (e[1] && run && ten && (st[0] || !i_acq_mode))
    begin
      ex_f++;
      st[1] = 1'b1;
    end
    if (e[0] && run) {run, st[2]} = 2'b01;
    @(posedge i_ref_clk);
    #1;
    i_evt = '0;
  endtask

  task automatic sync();
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk("run", o_ctl.run_active, run);
    chk("trig_en", o_ctl.trig_enable, ten);
    chk("push", np, ex_p);
    chk("fire", nf, ex_f);
    chk("reset", nr, ex_r);
    chk("pending", nwd, ex_w);
    rd(crcs_pkg::OFS_STATUS, {29'h0, st});
  endtask

  // Waits for the end of a pending wait, k holds the cycles spent
  task automatic wend(input logic [2:0] c, input int hi);
    k = 0;
    while (nwd == ex_w && k < hi)
    begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    ex_w++;
    chk("wdone", nwd, ex_w);
    chk("wcode", wcode, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run length
  initial
  begin
    #100000;
    n_errors++;
    final_report();
  end

  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    rd(crcs_pkg::OFS_STATUS, 32'h0);
    rd(crcs_pkg::OFS_TIMEOUT_MS, 32'h0);
    rd(crcs_pkg::OFS_COMMAND, 32'h0);
    rd(20'h00010, 32'h0);
    bus(1'b1, 20'h00010, 32'h4);
    chk("unmapped", o_code, crcs_pkg::RES_BADREG);
    // Refused words while idle, generation mode for the pretrigger wait
    i_acq_mode = 1'b0;
    foreach (bad[i]) cmd(bad[i]);
    i_acq_mode = 1'b1;
    cmd(32'h40);
    i_cfg_changed = 1'($random(seed));
    cmd(32'h2);
    sync();
    cmd(32'h4);
    cmd(32'h4);
    sync();
    // Trigger held off until the pretrigger area fills
    cmd(32'h8);
    ev(3'b010);
    cmd(32'h1000);
    sync();
    ev(3'b100);
    wend(crcs_pkg::RES_OK, 20);
    sync();
    // Timeout with detection off; card state must not move
    t = 1 + ($unsigned($random(seed)) % 3);
    bus(1'b1, crcs_pkg::OFS_TIMEOUT_MS, t);
    rd(crcs_pkg::OFS_TIMEOUT_MS, t);
    cmd(32'h20);
    cmd(32'h2000);
    ev(3'b010);
    wend(crcs_pkg::RES_TIMEOUT, t * MS + 20);
    chk("tmo_len", k >= t * MS - 4 && k <= t * MS + 5, 1'b1);
    sync();
    cmd(32'h4000);
    wend(crcs_pkg::RES_TIMEOUT, t * MS + 20);
    bus(1'b1, crcs_pkg::OFS_TIMEOUT_MS, 32'h0);
    // Zero timeout blocks until the first trigger only
    cmd(32'h8);
    cmd(32'h2000);
    repeat (3 * MS) @(posedge i_ref_clk);
    #1;
    sync();
    ev(3'b010);
    wend(crcs_pkg::RES_OK, 20);
    ev(3'b010);
    sync();
    cmd(32'h4000);
    cmd(32'h40);
    wend(crcs_pkg::RES_ABORT, 20);
    sync();
    // Several commands in one word, fresh run clears status
    cmd(32'h0C);
    sync();
    cmd(32'h4000);
    ev(3'b001);
    wend(crcs_pkg::RES_OK, 20);
    sync();
    cmd(32'h14);
    sync();
    bus(1'b1, crcs_pkg::OFS_TIMEOUT_MS, 32'h5);
    cmd(32'h1);
    sync();
    rd(crcs_pkg::OFS_TIMEOUT_MS, 32'h0);
    // Generation mode: no pretrigger gate and no pretrigger status
    i_acq_mode = 1'b0;
    cmd(32'h0C);
    ev(3'b100);
    sync();
    ev(3'b010);
    sync();
    final_report();
  end
endmodule
